// ---- hw/rrar_pkg.sv ----
// Shared constants and types for the remapping register bank
package rrar_pkg;

  // Region geometry
  localparam int REGION_BITS = 12;
  localparam int IDX_W = REGION_BITS - 2;
  localparam logic [31:0] BASE_MASK =
    ~((32'h0000_0001 << REGION_BITS) - 32'h0000_0001);
  localparam logic [31:0] DW_ALIGN = 32'h0000_0003;
  localparam logic [31:0] QW_ALIGN = 32'h0000_0007;
  localparam logic [31:0] DW_STEP = 32'h0000_0004;

  // Dword indices inside the region
  localparam logic [IDX_W-1:0] IDX_ID = 10'h000;
  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h001;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h002;
  localparam logic [IDX_W-1:0] IDX_STICKY_STATUS = 10'h003;
  localparam logic [IDX_W-1:0] IDX_LOCK = 10'h004;
  localparam logic [IDX_W-1:0] IDX_LOCK_CFG = 10'h005;
  localparam logic [IDX_W-1:0] IDX_LOCK_VOL = 10'h006;
  localparam logic [IDX_W-1:0] IDX_STICKY_RO = 10'h007;
  localparam logic [IDX_W-1:0] IDX_CMD = 10'h008;
  localparam logic [IDX_W-1:0] IDX_WIDE_LO = 10'h00a;
  localparam logic [IDX_W-1:0] IDX_WIDE_HI = 10'h00b;
  localparam logic [IDX_W-1:0] IDX_BASE = 10'h00c;

  // Field widths and bit positions
  localparam int CTRL_W = 8;
  localparam int EVT_W = 8;
  localparam int FIELD_W = 16;
  localparam int CTRL_EVT_EN = 0;
  localparam int LOCK_BIT = 0;

  typedef enum logic [1:0] {
    RRAR_IDLE,
    RRAR_LOW,
    RRAR_HIGH
  } rrar_fsm_t;

  typedef struct packed {
    rrar_fsm_t fsm;
    logic [31:0] addr;
    logic [63:0] wdata;
    logic we;
    logic quad;
    logic ack;
    logic err;
    logic [63:0] rdata;
    logic cmd;
    logic [31:0] cmd_data;
    logic [CTRL_W-1:0] ctrl;
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] sticky_status;
    logic lock;
    logic [FIELD_W-1:0] lk_cfg;
    logic [FIELD_W-1:0] lk_vol;
    logic [FIELD_W-1:0] sticky_ro;
    logic [63:0] wide;
    logic [31:0] base;
  } rrar_st_t;

endpackage : rrar_pkg

// ---- hw/rrar_bank.sv ----
// Remapping register bank with field attribute handling
`timescale 1ns/1ps

module rrar_bank #(
  parameter logic [31:0] ID_VALUE = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] DEFAULT_BASE = 32'h0001_0000
) (
  // Clock and resets
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic PWR_GOOD_RST_I,
  // Access port
  input wire logic REQ_I,
  input wire logic WE_I,
  input wire logic QUAD_I,
  input wire logic LOCKED_I,
  input wire logic [31:0] ADDR_I,
  input wire logic [63:0] WDATA_I,
  output logic READY_O,
  output logic ACK_O,
  output logic ERR_O,
  output logic [63:0] RDATA_O,
  // Hardware side events
  input wire logic [rrar_pkg::EVT_W-1:0] EVENT_I,
  input wire logic [rrar_pkg::EVT_W-1:0] ERROR_I,
  input wire logic [rrar_pkg::FIELD_W-1:0] ERR_CODE_I,
  input wire logic VOL_UPD_I,
  input wire logic [rrar_pkg::FIELD_W-1:0] VOL_DATA_I,
  // Register contents to the block
  output logic [rrar_pkg::CTRL_W-1:0] CTRL_O,
  output logic [rrar_pkg::FIELD_W-1:0] LOCK_CFG_O,
  output logic [rrar_pkg::FIELD_W-1:0] LOCK_VOL_O,
  output logic [63:0] WIDE_O,
  output logic [31:0] BASE_O,
  output logic LOCKED_O,
  output logic CMD_O,
  output logic [31:0] CMD_DATA_O
);

  rrar_pkg::rrar_st_t st;
  rrar_pkg::rrar_st_t next_st;

  // One doubleword access; upper selects the read data half
  function automatic rrar_pkg::rrar_st_t dw_access(
    input rrar_pkg::rrar_st_t s,
    input logic [31:0] a,
    input logic [31:0] d,
    input logic up
  );
    rrar_pkg::rrar_st_t r;
    logic [rrar_pkg::IDX_W-1:0] idx;
    logic [31:0] rd;
    logic w;
    r = s;
    idx = a[rrar_pkg::REGION_BITS-1:2];
    rd = '0;
    w = s.we;
    if ((a & rrar_pkg::BASE_MASK) == s.base) begin
      case (idx)
        rrar_pkg::IDX_ID: rd = ID_VALUE;
        rrar_pkg::IDX_CTRL: begin
          rd = 32'(s.ctrl);
          if (w) r.ctrl = d[rrar_pkg::CTRL_W-1:0];
        end
        rrar_pkg::IDX_STATUS: begin
          rd = 32'(s.status);
          if (w) r.status = s.status & ~d[rrar_pkg::EVT_W-1:0];
        end
        rrar_pkg::IDX_STICKY_STATUS: begin
          rd = 32'(s.sticky_status);
          if (w) begin
            r.sticky_status = s.sticky_status &
              ~d[rrar_pkg::EVT_W-1:0];
          end
        end
        rrar_pkg::IDX_LOCK: begin
          rd = 32'(s.lock);
          // Set once; only a reset unlocks
          if (w && d[rrar_pkg::LOCK_BIT]) r.lock = 1'b1;
        end
        rrar_pkg::IDX_LOCK_CFG: begin
          rd = 32'(s.lk_cfg);
          if (w && !s.lock) r.lk_cfg = d[rrar_pkg::FIELD_W-1:0];
        end
        rrar_pkg::IDX_LOCK_VOL: begin
          rd = 32'(s.lk_vol);
          if (w && !s.lock) r.lk_vol = d[rrar_pkg::FIELD_W-1:0];
        end
        rrar_pkg::IDX_STICKY_RO: rd = 32'(s.sticky_ro);
        rrar_pkg::IDX_CMD: begin
          // Reads return zero; software must not rely on it
          if (w) begin
            r.cmd = 1'b1;
            r.cmd_data = d;
          end
        end
        rrar_pkg::IDX_WIDE_LO: begin
          rd = s.wide[31:0];
          if (w) r.wide[31:0] = d;
        end
        rrar_pkg::IDX_WIDE_HI: begin
          rd = s.wide[63:32];
          if (w) r.wide[63:32] = d;
        end
        rrar_pkg::IDX_BASE: begin
          rd = s.base;
          if (w && !s.lock) r.base = d & rrar_pkg::BASE_MASK;
        end
        default: ; // Unmapped dwords read zero, ignore writes
      endcase
    end
    if (up) begin
      r.rdata[63:32] = rd;
    end else begin
      r.rdata[31:0] = rd;
    end
    return r;
  endfunction : dw_access

  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.err = 1'b0;
    next_st.cmd = 1'b0;
    case (st.fsm)
      rrar_pkg::RRAR_IDLE: begin
        if (REQ_I) begin
          // Locked operations and misaligned accesses are refused
          if (LOCKED_I || (ADDR_I & (QUAD_I ? rrar_pkg::QW_ALIGN
                                            : rrar_pkg::DW_ALIGN)) != '0) begin
            next_st.ack = 1'b1;
            next_st.err = 1'b1;
            next_st.rdata = '0;
          end else begin
            next_st.addr = ADDR_I;
            next_st.wdata = WDATA_I;
            next_st.we = WE_I;
            next_st.quad = QUAD_I;
            next_st.rdata = '0;
            next_st.fsm = rrar_pkg::RRAR_LOW;
          end
        end
      end
      rrar_pkg::RRAR_LOW: begin
        next_st = dw_access(next_st, st.addr, st.wdata[31:0], 1'b0);
        if (st.quad) begin
          next_st.fsm = rrar_pkg::RRAR_HIGH;
        end else begin
          next_st.fsm = rrar_pkg::RRAR_IDLE;
          next_st.ack = 1'b1;
        end
      end
      rrar_pkg::RRAR_HIGH: begin
        next_st = dw_access(next_st, st.addr + rrar_pkg::DW_STEP,
                            st.wdata[63:32], 1'b1);
        next_st.fsm = rrar_pkg::RRAR_IDLE;
        next_st.ack = 1'b1;
      end
      default: next_st.fsm = rrar_pkg::RRAR_IDLE;
    endcase
    // Hardware sets after the clear so a same-cycle event is kept
    if (st.ctrl[rrar_pkg::CTRL_EVT_EN]) begin
      next_st.status = next_st.status | EVENT_I;
    end
    next_st.sticky_status = next_st.sticky_status | ERROR_I;
    if (ERROR_I != '0 && st.sticky_ro == '0) begin
      next_st.sticky_ro = ERR_CODE_I;
    end
    if (VOL_UPD_I) next_st.lk_vol = VOL_DATA_I;
    // Ordinary reset keeps sticky fields; power-good clears all
    if (PWR_GOOD_RST_I || SYS_RST_I) begin
      next_st = '0;
      next_st.base = DEFAULT_BASE & rrar_pkg::BASE_MASK;
      if (!PWR_GOOD_RST_I) begin
        next_st.sticky_status = st.sticky_status;
        next_st.sticky_ro = st.sticky_ro;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    st <= next_st;
  end

  assign READY_O = (st.fsm == rrar_pkg::RRAR_IDLE);
  assign ACK_O = st.ack;
  assign ERR_O = st.err;
  assign RDATA_O = st.rdata;
  assign CTRL_O = st.ctrl;
  assign LOCK_CFG_O = st.lk_cfg;
  assign LOCK_VOL_O = st.lk_vol;
  assign WIDE_O = st.wide;
  assign BASE_O = st.base;
  assign LOCKED_O = st.lock;
  assign CMD_O = st.cmd;
  assign CMD_DATA_O = st.cmd_data;

  // Checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I || PWR_GOOD_RST_I);

  logic wr_status;
  assign wr_status = st.we && st.fsm == rrar_pkg::RRAR_LOW &&
    st.addr[rrar_pkg::REGION_BITS-1:2] == rrar_pkg::IDX_STATUS;

  logic [rrar_pkg::IDX_W-1:0] cur_idx;
  assign cur_idx = st.addr[rrar_pkg::REGION_BITS-1:2];

  a_base_align: assert property (
    (st.base & ~rrar_pkg::BASE_MASK) == '0)
    else $error("Region base not size aligned");

  a_base_locked: assert property (
    st.lock && !SYS_RST_I |=> $stable(st.base))
    else $error("Base moved while locked");

  a_quad_order: assert property (
    READY_O && REQ_I && QUAD_I && !LOCKED_I &&
    (ADDR_I & rrar_pkg::QW_ALIGN) == '0
    |=> st.fsm == rrar_pkg::RRAR_LOW ##1
        st.fsm == rrar_pkg::RRAR_HIGH && !ACK_O ##1 ACK_O && !ERR_O)
    else $error("Quadword halves out of order");

  a_rw_store: assert property (
    st.fsm == rrar_pkg::RRAR_LOW && st.we && !st.quad &&
    (st.addr & rrar_pkg::BASE_MASK) == st.base &&
    st.addr[rrar_pkg::REGION_BITS-1:2] == rrar_pkg::IDX_WIDE_LO
    |=> st.wide[31:0] == $past(st.wdata[31:0]))
    else $error("Read-write field lost write");

  a_w1c_noclear: assert property (
    !wr_status |=> (st.status & $past(st.status)) == $past(st.status))
    else $error("Status cleared without a write");

  a_sticky_keep: assert property (
    @(posedge SYS_CLK_I) disable iff (PWR_GOOD_RST_I)
    SYS_RST_I |=> st.sticky_status == $past(st.sticky_status) &&
                  st.sticky_ro == $past(st.sticky_ro))
    else $error("Sticky field lost on ordinary reset");

  a_lock_cfg: assert property (
    st.lock |=> $stable(st.lk_cfg))
    else $error("Locked field changed");

  a_vol_update: assert property (
    VOL_UPD_I |=> st.lk_vol == $past(VOL_DATA_I))
    else $error("Volatile field missed hardware update");

  a_sticky_ro: assert property (
    st.sticky_ro != '0 |=> $stable(st.sticky_ro))
    else $error("Sticky read-only field changed");

  a_locked_refused: assert property (
    READY_O && REQ_I && LOCKED_I |=> ACK_O && ERR_O && READY_O)
    else $error("Locked operation not refused");

  a_id_const: assert property (
    st.fsm == rrar_pkg::RRAR_LOW && !st.quad &&
    cur_idx == rrar_pkg::IDX_ID &&
    (st.addr & rrar_pkg::BASE_MASK) == st.base
    |=> RDATA_O[31:0] == ID_VALUE)
    else $error("Identity register changed");

  a_unused_zero: assert property (
    st.fsm == rrar_pkg::RRAR_LOW && !st.quad &&
    (cur_idx == rrar_pkg::IDX_CMD || cur_idx > rrar_pkg::IDX_BASE)
    |=> RDATA_O == '0)
    else $error("Reserved or write-only dword read nonzero");

  a_upper_zero: assert property (
    st.fsm == rrar_pkg::RRAR_LOW && !st.quad |=> RDATA_O[63:32] == '0)
    else $error("Dword read upper half nonzero");

  a_cmd_pulse: assert property (
    CMD_O |=> !CMD_O)
    else $error("Command strobe longer than one cycle");

  a_ro_write: assert property (
    st.fsm == rrar_pkg::RRAR_LOW && st.we && ERROR_I == '0
    |=> $stable(st.sticky_ro))
    else $error("Sticky read-only field changed by a write");

  c_quad_write: cover property (
    st.fsm == rrar_pkg::RRAR_HIGH && st.we ##1 ACK_O);
  c_dword_read: cover property (
    st.fsm == rrar_pkg::RRAR_LOW && !st.we && !st.quad ##1 ACK_O);
  c_lock_set: cover property ($rose(st.lock));
  c_clear_race: cover property (wr_status && EVENT_I != '0);
  c_vol_locked: cover property (st.lock && VOL_UPD_I);

endmodule : rrar_bank

// ---- tb/rrar_host.sv ----
// Host software model issuing register accesses at the address given, aligned or not
`timescale 1ns/1ps
module rrar_host (
  // Clock and answer
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic ack_i,
  input wire logic err_i,
  input wire logic [63:0] rdata_i,
  // Request
  output logic req_o,
  output logic we_o,
  output logic quad_o,
  output logic locked_o,
  output logic [31:0] addr_o,
  output logic [63:0] wdata_o
);
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    quad_o = 1'b0;
    locked_o = 1'b0;
    addr_o = 32'h0;
    wdata_o = 64'h0;
  end

  // Whole dword or qword at the given address, not aligned here; locked only when asked
  // Callers write raw values; reserved fields are not merged
  task automatic access(input logic we, input logic quad, input logic lk,
    input logic [31:0] a, input logic [63:0] d,
    output logic [63:0] rd, output logic er);
    int n;
    n = 0;
    req_o = 1'b1;
    we_o = we;
    quad_o = quad;
    locked_o = lk;
    addr_o = a;
    wdata_o = d;
    // Ready only moves on edges, so its value now is what the edge sees
    while (ready_i !== 1'b1) begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    #1;
    // Released lines toggle so stale values cannot pass
    req_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
    while (ack_i !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    rd = (n < 20) ? rdata_i : 64'hx;
    er = (n < 20) ? err_i : 1'bx;
  endtask : access
endmodule : rrar_host

// ---- tb/remap_register_access_rules_tb.sv ----
// Self-checking bench for the remapping register bank
`timescale 1ns/1ps
module remap_register_access_rules_tb;
  localparam logic [31:0] ID_V = 32'h0000_00a5; // Arbitrary value
  logic clk, rst, pgr, req, we, quad, lkd, rdy, ack, err, vu;
  logic [31:0] addr, base;
  logic [63:0] wd, rdat, r;
  logic [7:0] ev, er;
  logic [15:0] code, vd, lfsr;
  logic [31:0] cmd_d;
  logic [7:0] ctrl;
  logic [15:0] lkc, lkv;
  logic [63:0] wide, qd;
  logic cmd;
  logic lk_o, e, lk;
  logic [31:0] mdl [16];
  int n_fail = 0;
  int num_checks = 0;

  rrar_bank #(.ID_VALUE(ID_V)) uut (.SYS_CLK_I(clk), .SYS_RST_I(rst),
    .PWR_GOOD_RST_I(pgr), .REQ_I(req), .WE_I(we), .QUAD_I(quad),
    .LOCKED_I(lkd), .ADDR_I(addr), .WDATA_I(wd), .READY_O(rdy),
    .ACK_O(ack), .ERR_O(err), .RDATA_O(rdat), .EVENT_I(ev),
    .ERROR_I(er), .ERR_CODE_I(code), .VOL_UPD_I(vu), .VOL_DATA_I(vd),
    .CTRL_O(ctrl), .LOCK_CFG_O(lkc), .LOCK_VOL_O(lkv), .WIDE_O(wide),
    .BASE_O(base), .LOCKED_O(lk_o), .CMD_O(cmd), .CMD_DATA_O(cmd_d));
  rrar_host host (.clk_i(clk), .ready_i(rdy), .ack_i(ack), .err_i(err),
    .rdata_i(rdat), .req_o(req), .we_o(we), .quad_o(quad),
    .locked_o(lkd), .addr_o(addr), .wdata_o(wd));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // Register outputs mirror the model
  task automatic chk_outs();
    chk(ctrl, mdl[1]);
    chk(lkc, mdl[5]);
    chk(lkv, mdl[6]);
    chk(wide, {mdl[11], mdl[10]});
    chk(base, mdl[12]);
    chk(lk_o, lk);
  endtask : chk_outs

  // Sticky entries survive the plain reset only
  task automatic reset_mdl(input logic pg);
    for (int i = 0; i < 16; i++) if (pg || (i != 3 && i != 7)) mdl[i] = 0;
    lk = 1'b0;
    mdl[0] = ID_V;
    mdl[12] = 32'h0001_0000;
  endtask : reset_mdl

  task automatic do_reset(input logic pg);
    rst = 1'b1;
    pgr = pg;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    pgr = 1'b0;
    reset_mdl(pg);
  endtask : do_reset

  task automatic wr(input int off, input logic [31:0] d);
    host.access(1'b1, 1'b0, 1'b0, mdl[12] + 32'(off), 64'(d), r, e);
    chk(cmd, off == 32);
    case (off)
      4: mdl[1] = d & 32'h0000_00ff;
      8, 12: mdl[off/4] = mdl[off/4] & ~d;
      16: if (d[0]) lk = 1'b1;
      20, 24: if (!lk) mdl[off/4] = d & 32'h0000_ffff;
      40, 44: mdl[off/4] = d;
      48: if (!lk) mdl[12] = d & 32'hffff_f000;
      default: ;
    endcase
    mdl[4] = {31'h0, lk};
  endtask : wr

  task automatic rd(input int off);
    host.access(1'b0, 1'b0, 1'b0, mdl[12] + 32'(off), 64'h0, r, e);
    chk(r, {32'h0, mdl[off/4]});
    chk(e, 1'b0);
    chk_outs();
  endtask : rd

  task automatic hw(input logic [7:0] a, input logic [7:0] b,
    input logic [15:0] c, input logic u, input logic [15:0] v);
    ev = a;
    er = b;
    code = c;
    vu = u;
    vd = v;
    @(posedge clk);
    #1;
    {ev, er, code, vu, vd} = '0;
  endtask : hw

  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    #100000;
    n_fail++;
    stop_test();
  end

  initial begin
    {rst, pgr} = 2'b11;
    {ev, er, code, vu, vd} = '0;
    lfsr = 16'h0030;
    repeat (10) @(posedge clk);
    #1;
    {rst, pgr} = 2'b00;
    reset_mdl(1'b1);
    wr(0, 32'hffff_ffff);
    rd(0);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      wr(4, {lfsr, ~lfsr});
      rd(4);
    end
    wr(4, 32'h1);
    hw(8'h0f, 8'h30, 16'h1234, 1'b0, 16'h0);
    mdl[2] = 32'h0f;
    mdl[3] = 32'h30;
    mdl[7] = 32'h1234;
    wr(8, 32'h5);
    rd(8);
    // Event lands in the clearing cycle; the set must win
    fork
      wr(8, 32'h2);
      begin
        @(posedge clk);
        #1;
        hw(8'h02, 8'h0, 16'h0, 1'b0, 16'h0);
      end
    join
    mdl[2] = mdl[2] | 32'h2;
    rd(8);
    wr(28, 32'hffff);
    rd(28);
    do_reset(1'b0);
    rd(12);
    rd(28);
    rd(4);
    wr(12, 32'h10);
    rd(12);
    do_reset(1'b1);
    rd(12);
    rd(28);
    rd(36);
    // Event enable is clear after reset, so status stays empty
    hw(8'hf0, 8'h0, 16'h0, 1'b0, 16'h0);
    rd(8);
    wr(32, 32'hcafe_0001);
    chk(cmd_d, 32'hcafe_0001);
    rd(32);
    qd = 64'h89ab_cdef_0123_4567;
    host.access(1'b1, 1'b1, 1'b0, mdl[12] + 32'h28, qd, r, e);
    chk(e, 1'b0);
    mdl[10] = 32'h0123_4567;
    mdl[11] = 32'h89ab_cdef;
    rd(40);
    rd(44);
    host.access(1'b0, 1'b1, 1'b0, mdl[12] + 32'h28, 64'h0, r, e);
    chk(r, {mdl[11], mdl[10]});
    host.access(1'b1, 1'b0, 1'b1, mdl[12] + 32'h4, 64'h5, r, e);
    chk(e, 1'b1);
    rd(4);
    host.access(1'b0, 1'b0, 1'b0, mdl[12] + 32'h6, 64'h0, r, e);
    chk(e, 1'b1);
    wr(48, 32'h0002_0abc);
    chk(base, mdl[12]);
    rd(4);
    wr(20, 32'hbeef);
    wr(24, 32'h00ff);
    rd(24);
    wr(16, 32'h1);
    chk(lk_o, 1'b1);
    rd(16);
    wr(20, 32'h1111);
    rd(20);
    wr(48, 32'h0003_0000);
    chk(base, mdl[12]);
    rd(48);
    hw(8'h0, 8'h0, 16'h0, 1'b1, 16'h5a5a);
    mdl[6] = 32'h5a5a;
    wr(24, 32'h0f0f);
    rd(24);
    stop_test();
  end
endmodule : remap_register_access_rules_tb
